//--- hw/tlm_top.v
// Temperature limit monitor: limit registers, averagers, signed comparisons, flags and interrupt.
// Assumes samples come from converters on the same clock and a plain register port.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tlm_consts.vh"
module tlm_top #(
  parameter W = 12
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [`TLM_ADDR_W-1:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  input wire int_smp_vld_i,
  input wire [W-1:0] int_smp_i,
  input wire ext1_smp_vld_i,
  input wire [W-1:0] ext1_smp_i,
  input wire ext2_smp_vld_i,
  input wire [W-1:0] ext2_smp_i,
  output reg [2:0] int_temp_flags_o,
  output reg [2:0] first_ext_temp_flags_o,
  output reg [2:0] second_ext_temp_flags_o,
  output reg irq_o
);

  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n;

  // Reset is released through two flops so all logic leaves reset on the same edge.
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Signed compare: true when a is strictly greater than b.
  function gt_signed;
    input [W-1:0] a;
    input [W-1:0] b;
    begin
      gt_signed = $signed(a) > $signed(b);
    end
  endfunction

  reg [W-1:0] internal_high_limit_q;
  reg [W-1:0] internal_low_limit_q;
  reg [W-1:0] first_ext_high_limit_q;
  reg [W-1:0] first_ext_low_limit_q;
  reg [W-1:0] second_ext_high_limit_q;
  reg [W-1:0] second_ext_low_limit_q;
  reg [5:0] internal_average_count_q;
  reg [5:0] irq_mask_q;
  reg [5:0] irq_stat_q;
  reg [5:0] irq_stat_d;
  reg [W-1:0] int_res_q;
  reg [W-1:0] ext1_res_q;
  reg [W-1:0] ext2_res_q;

  wire int_vld;
  wire ext1_vld;
  wire ext2_vld;
  wire [W-1:0] int_avg;
  wire [W-1:0] ext1_avg;
  wire [W-1:0] ext2_avg;

  // One averager per channel, each with its own two-bit sample-count code.
  tlm_avg #(.W(W)) u_avg_int (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .avg_sel_i(internal_average_count_q[1:0]),
    .smp_vld_i(int_smp_vld_i),
    .smp_i(int_smp_i),
    .res_vld_o(int_vld),
    .res_o(int_avg)
  );

  tlm_avg #(.W(W)) u_avg_ext1 (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .avg_sel_i(internal_average_count_q[3:2]),
    .smp_vld_i(ext1_smp_vld_i),
    .smp_i(ext1_smp_i),
    .res_vld_o(ext1_vld),
    .res_o(ext1_avg)
  );

  tlm_avg #(.W(W)) u_avg_ext2 (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .avg_sel_i(internal_average_count_q[5:4]),
    .smp_vld_i(ext2_smp_vld_i),
    .smp_i(ext2_smp_i),
    .res_vld_o(ext2_vld),
    .res_o(ext2_avg)
  );

  // Limit and configuration writes.
  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      internal_high_limit_q <= `TLM_HI_RESET;
      internal_low_limit_q <= `TLM_LO_RESET;
      first_ext_high_limit_q <= `TLM_HI_RESET;
      first_ext_low_limit_q <= `TLM_LO_RESET;
      second_ext_high_limit_q <= `TLM_HI_RESET;
      second_ext_low_limit_q <= `TLM_LO_RESET;
      internal_average_count_q <= `TLM_AVG_RESET;
      irq_mask_q <= `TLM_MASK_RESET;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `TLM_OFF_INT_HI: internal_high_limit_q <= reg_wdata_i[W-1:0];
        `TLM_OFF_INT_LO: internal_low_limit_q <= reg_wdata_i[W-1:0];
        `TLM_OFF_EXT1_HI: first_ext_high_limit_q <= reg_wdata_i[W-1:0];
        `TLM_OFF_EXT1_LO: first_ext_low_limit_q <= reg_wdata_i[W-1:0];
        `TLM_OFF_EXT2_HI: second_ext_high_limit_q <= reg_wdata_i[W-1:0];
        `TLM_OFF_EXT2_LO: second_ext_low_limit_q <= reg_wdata_i[W-1:0];
        `TLM_OFF_AVG_CFG: internal_average_count_q <= reg_wdata_i[5:0];
        `TLM_OFF_IRQ_MASK: irq_mask_q <= reg_wdata_i[5:0];
        default: irq_mask_q <= irq_mask_q;
      endcase
    end
  end

  // Latest averaged results, kept so software can read what was compared.
  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_res_q <= {W{1'b0}};
      ext1_res_q <= {W{1'b0}};
      ext2_res_q <= {W{1'b0}};
    end
    else
    begin
      if (int_vld)
        int_res_q <= int_avg;
      if (ext1_vld)
        ext1_res_q <= ext1_avg;
      if (ext2_vld)
        ext2_res_q <= ext2_avg;
    end
  end

  // Flags are refreshed only when a new averaged result arrives; they then hold.
  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_temp_flags_o <= 3'h0;
      first_ext_temp_flags_o <= 3'h0;
      second_ext_temp_flags_o <= 3'h0;
    end
    else
    begin
      if (int_vld)
      begin
        int_temp_flags_o[`TLM_FLAG_HI_BIT] <= gt_signed(int_avg, internal_high_limit_q);
        int_temp_flags_o[`TLM_FLAG_LO_BIT] <= gt_signed(internal_low_limit_q, int_avg);
      end
      if (ext1_vld)
      begin
        first_ext_temp_flags_o[`TLM_FLAG_HI_BIT] <=
          gt_signed(ext1_avg, first_ext_high_limit_q);
        first_ext_temp_flags_o[`TLM_FLAG_LO_BIT] <=
          gt_signed(first_ext_low_limit_q, ext1_avg);
      end
      if (ext2_vld)
      begin
        second_ext_temp_flags_o[`TLM_FLAG_HI_BIT] <=
          gt_signed(ext2_avg, second_ext_high_limit_q);
        second_ext_temp_flags_o[`TLM_FLAG_LO_BIT] <=
          gt_signed(second_ext_low_limit_q, ext2_avg);
      end
    end
  end

  // Sticky events: bits {ext2 hi, ext2 lo, ext1 hi, ext1 lo, int hi, int lo}.
  // A new event in the same cycle as a write-one clear wins, so no event is lost.
  wire [5:0] evt_w;
  assign evt_w[0] = int_vld && gt_signed(internal_low_limit_q, int_avg);
  assign evt_w[1] = int_vld && gt_signed(int_avg, internal_high_limit_q);
  assign evt_w[2] = ext1_vld && gt_signed(first_ext_low_limit_q, ext1_avg);
  assign evt_w[3] = ext1_vld && gt_signed(ext1_avg, first_ext_high_limit_q);
  assign evt_w[4] = ext2_vld && gt_signed(second_ext_low_limit_q, ext2_avg);
  assign evt_w[5] = ext2_vld && gt_signed(ext2_avg, second_ext_high_limit_q);

  always @*
  begin
    irq_stat_d = irq_stat_q;
    if (reg_wr_i && reg_addr_i == `TLM_OFF_IRQ_STAT)
      irq_stat_d = irq_stat_d & ~reg_wdata_i[5:0];
    irq_stat_d = irq_stat_d | evt_w;
  end

  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_q <= 6'h00;
      irq_o <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_o <= |(irq_stat_d & irq_mask_q);
    end
  end

  // Read port: data stand one cycle after the strobe, zero otherwise and for unmapped words.
  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `TLM_OFF_INT_HI: reg_rdata_o <= {4'h0, internal_high_limit_q};
        `TLM_OFF_INT_LO: reg_rdata_o <= {4'h0, internal_low_limit_q};
        `TLM_OFF_EXT1_HI: reg_rdata_o <= {4'h0, first_ext_high_limit_q};
        `TLM_OFF_EXT1_LO: reg_rdata_o <= {4'h0, first_ext_low_limit_q};
        `TLM_OFF_EXT2_HI: reg_rdata_o <= {4'h0, second_ext_high_limit_q};
        `TLM_OFF_EXT2_LO: reg_rdata_o <= {4'h0, second_ext_low_limit_q};
        `TLM_OFF_AVG_CFG: reg_rdata_o <= {10'h000, internal_average_count_q};
        `TLM_OFF_INT_FLAGS: reg_rdata_o <= {13'h0, int_temp_flags_o};
        `TLM_OFF_EXT1_FLAGS: reg_rdata_o <= {13'h0, first_ext_temp_flags_o};
        `TLM_OFF_EXT2_FLAGS: reg_rdata_o <= {13'h0, second_ext_temp_flags_o};
        `TLM_OFF_IRQ_STAT: reg_rdata_o <= {10'h000, irq_stat_q};
        `TLM_OFF_IRQ_MASK: reg_rdata_o <= {10'h000, irq_mask_q};
        `TLM_OFF_INT_RES: reg_rdata_o <= {4'h0, int_res_q};
        `TLM_OFF_EXT1_RES: reg_rdata_o <= {4'h0, ext1_res_q};
        `TLM_OFF_EXT2_RES: reg_rdata_o <= {4'h0, ext2_res_q};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
    else
      reg_rdata_o <= 16'h0000;
  end

endmodule
`default_nettype wire

//--- hw/tlm_consts.vh
// Constants for the temperature limit monitor: register offsets, reset values, field positions.
// Assumes a plain register port with word addresses and 16-bit read data.
//
// Operation
// - Internal low flag (bit 1) set while internal reading is below its low limit.
// - First external high flag (bit 2) set while its reading exceeds its high limit.
// - First external low flag (bit 1) set while its reading is below its low limit.
// - Second external high flag (bit 2) set while its reading exceeds its high limit.
// - Second external low flag (bit 1) set while its reading is below its low limit.
// - Limits are signed two's complement, 0.125 degree per bit, compared signed.
// - Internal high flag (bit 2) set while internal reading exceeds its high limit.
// - Each result averages 4, 8, 16 or 32 samples, chosen by a two-bit code.
`ifndef TLM_CONSTS_VH
`define TLM_CONSTS_VH

`define TLM_ADDR_W 4
`define TLM_OFF_INT_HI 4'h0
`define TLM_OFF_INT_LO 4'h1
`define TLM_OFF_EXT1_HI 4'h2
`define TLM_OFF_EXT1_LO 4'h3
`define TLM_OFF_EXT2_HI 4'h4
`define TLM_OFF_EXT2_LO 4'h5
`define TLM_OFF_AVG_CFG 4'h6
`define TLM_OFF_INT_FLAGS 4'h7
`define TLM_OFF_EXT1_FLAGS 4'h8
`define TLM_OFF_EXT2_FLAGS 4'h9
`define TLM_OFF_IRQ_STAT 4'ha
`define TLM_OFF_IRQ_MASK 4'hb
`define TLM_OFF_INT_RES 4'hc
`define TLM_OFF_EXT1_RES 4'hd
`define TLM_OFF_EXT2_RES 4'he

`define TLM_HI_RESET 12'h7ff
`define TLM_LO_RESET 12'h800
`define TLM_AVG_RESET 6'h00
`define TLM_MASK_RESET 6'h00

`define TLM_FLAG_LO_BIT 1
`define TLM_FLAG_HI_BIT 2

`endif

//--- hw/tlm_avg.v
// Sample averager for one temperature channel: accumulates 4 to 32 samples and emits the mean.
// Assumes samples arrive as one-cycle strobes on the same clock, signed 12-bit.
`timescale 1ns/1ps
`default_nettype none
module tlm_avg #(
  parameter W = 12
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [1:0] avg_sel_i,
  input wire smp_vld_i,
  input wire [W-1:0] smp_i,
  output reg res_vld_o,
  output reg [W-1:0] res_o
);

  // Accumulator wide enough for 32 signed samples.
  reg signed [W+4:0] acc_q;
  reg [4:0] cnt_q;
  wire [4:0] last_w;
  wire signed [W+4:0] sum_w;
  wire signed [W+4:0] mean_w;

  // Code n selects 2^(n+2) samples.
  // For code 3 the shift wraps to zero in five bits, so the last count is still 31.
  assign last_w = (5'h04 << avg_sel_i) - 5'h01;
  assign sum_w = acc_q + {{5{smp_i[W-1]}}, smp_i};
  assign mean_w = sum_w >>> ({1'b0, avg_sel_i} + 3'h2);

  // The count restarts after each result; the code is read live, so a change mid-block moves the end of the current block.
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc_q <= {(W+5){1'b0}};
      cnt_q <= 5'h00;
      res_vld_o <= 1'b0;
      res_o <= {W{1'b0}};
    end
    else
    begin
      res_vld_o <= 1'b0;
      if (smp_vld_i)
      begin
        if (cnt_q >= last_w)
        begin
          acc_q <= {(W+5){1'b0}};
          cnt_q <= 5'h00;
          res_vld_o <= 1'b1;
          res_o <= mean_w[W-1:0];
        end
        else
        begin
          acc_q <= sum_w;
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- bench/tlm_top_sva.sv
// Port checker for the temperature limit monitor.
// Assumes it is bound onto tlm_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module tlm_chk (
  input wire mclk_i,
  input wire rst_n_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_rdata_o,
  input wire int_smp_vld_i,
  input wire ext1_smp_vld_i,
  input wire ext2_smp_vld_i,
  input wire [2:0] int_temp_flags_o,
  input wire [2:0] first_ext_temp_flags_o,
  input wire [2:0] second_ext_temp_flags_o,
  input wire irq_o
);
  // Any sample strobe; irq may only rise from a result or a register write.
  wire any_vld = int_smp_vld_i | ext1_smp_vld_i | ext2_smp_vld_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Flags move only two or three edges after a sample closes a block.
  a_int_upd: assert property ($changed(int_temp_flags_o) |->
    $past(int_smp_vld_i, 2) || $past(int_smp_vld_i, 3)) else $error("int flags moved alone");
  a_ext1_upd: assert property ($changed(first_ext_temp_flags_o) |->
    $past(ext1_smp_vld_i, 2) || $past(ext1_smp_vld_i, 3)) else $error("ext1 flags moved alone");
  a_ext2_upd: assert property ($changed(second_ext_temp_flags_o) |->
    $past(ext2_smp_vld_i, 2) || $past(ext2_smp_vld_i, 3)) else $error("ext2 flags moved alone");
  // Bit 0 of every flag set carries no event.
  a_int_bit0: assert property (int_temp_flags_o[0] == 1'b0)
    else $error("int flag bit 0 set");
  a_ext1_bit0: assert property (first_ext_temp_flags_o[0] == 1'b0)
    else $error("ext1 flag bit 0 set");
  a_ext2_bit0: assert property (second_ext_temp_flags_o[0] == 1'b0)
    else $error("ext2 flag bit 0 set");
  // Read data stand only in the cycle after a read strobe.
  a_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside read cycle");
  a_irq_cause: assert property ($rose(irq_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2) ||
    $past(any_vld, 2) || $past(any_vld, 3)) else $error("irq rose without cause");
  c_int_hi: cover property ($rose(int_temp_flags_o[2]));
  c_ext2_lo: cover property ($rose(second_ext_temp_flags_o[1]));
  c_irq: cover property ($rose(irq_o));
endmodule
bind tlm_top tlm_chk chk_u (.mclk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .int_smp_vld_i, .ext1_smp_vld_i, .ext2_smp_vld_i, .int_temp_flags_o,
  .first_ext_temp_flags_o, .second_ext_temp_flags_o, .irq_o);
`default_nettype wire

//--- bench/tlm_top_tb_top.sv
// Self-checking bench for the temperature limit monitor.
// Assumes the register port and sample strobes share the one bench clock.
`timescale 1ns/1ps
`default_nettype none
`include "tlm_consts.vh"
module tlm_top_tb_top;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic vld = 1'b0;
  logic [11:0] smp = 12'h000;
  wire [15:0] rdata;
  wire [2:0] fl [3];
  wire irq;
  logic [11:0] hi [3];
  logic [11:0] lo [3];
  logic [11:0] tv [9] = '{12'h051, 12'h061, 12'h071, 12'h050, 12'hfaf, 12'hf9f, 12'hf8f,
    12'hfb0, 12'h800};
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  // All three channels see the same samples; distinct limits tell them apart.
  tlm_top dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .int_smp_vld_i(vld), .int_smp_i(smp),
    .ext1_smp_vld_i(vld), .ext1_smp_i(smp), .ext2_smp_vld_i(vld), .ext2_smp_i(smp),
    .int_temp_flags_o(fl[0]), .first_ext_temp_flags_o(fl[1]),
    .second_ext_temp_flags_o(fl[2]), .irq_o(irq));
  // Bench clock at 4 ns.
  initial
    forever #2 mclk_i = ~mclk_i;
  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  // Read data are looked at just after the edge that took the strobe.
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1;
    cmp(rdata, e);
  endtask
  // Flags hold until the next result, so four idle edges leave margin.
  task automatic feed(input logic [11:0] v, input int n);
    repeat (n)
    begin
      @(posedge mclk_i);
      vld <= 1'b1;
      smp <= v;
    end
    @(posedge mclk_i);
    vld <= 1'b0;
    repeat (4) @(posedge mclk_i);
    #1;
  endtask
  // Expected flags come from a signed, strict comparison of our own.
  task automatic chk_fl(input logic [11:0] v);
    for (int k = 0; k < 3; k++)
      cmp({13'h0, fl[k]}, {13'h0, $signed(v) > $signed(hi[k]), $signed(v) < $signed(lo[k]), 1'b0});
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    rd_reg(`TLM_OFF_INT_HI, 16'h07ff);
    rd_reg(`TLM_OFF_EXT2_LO, 16'h0800);
    rd_reg(4'hf, 16'h0000);
    for (int k = 0; k < 3; k++)
    begin
      hi[k] = 12'(12'h050 + 16 * k);
      lo[k] = 12'(12'hfb0 - 16 * k);
      wr_reg(4'(2 * k), {4'h0, hi[k]});
      wr_reg(4'(2 * k + 1), {4'h0, lo[k]});
      rd_reg(4'(2 * k + 1), {4'h0, lo[k]});
    end
    foreach (tv[i])
    begin
      feed(tv[i], 4);
      chk_fl(tv[i]);
    end
    // Status gathers every event; the mask decides whether irq follows.
    rd_reg(`TLM_OFF_IRQ_STAT, 16'h003f);
    cmp({15'h0, irq}, 16'h0000);
    wr_reg(`TLM_OFF_IRQ_MASK, 16'h0002);
    rd_reg(`TLM_OFF_IRQ_MASK, 16'h0002);
    cmp({15'h0, irq}, 16'h0001);
    wr_reg(`TLM_OFF_IRQ_STAT, 16'h003f);
    rd_reg(`TLM_OFF_IRQ_STAT, 16'h0000);
    cmp({15'h0, irq}, 16'h0000);
    feed(12'h051, 4);
    rd_reg(`TLM_OFF_IRQ_STAT, 16'h0002);
    cmp({15'h0, irq}, 16'h0001);
    wr_reg(`TLM_OFF_IRQ_STAT, 16'h0002);
    feed(12'hfaf, 4);
    rd_reg(`TLM_OFF_IRQ_STAT, 16'h0001);
    cmp({15'h0, irq}, 16'h0000);
    wr_reg(`TLM_OFF_INT_FLAGS, 16'h0004);
    rd_reg(`TLM_OFF_INT_FLAGS, 16'h0002);
    // Half high, half zero: only the full block gives half the high value.
    // The high value differs per code, so a block that never closes is caught.
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(`TLM_OFF_AVG_CFG, 16'(c * 21));
      feed(12'(12'h040 << c), 2 << c);
      feed(12'h000, 2 << c);
      chk_fl(12'(12'h020 << c));
      rd_reg(`TLM_OFF_INT_RES, 16'(12'h020 << c));
      rd_reg(`TLM_OFF_EXT2_RES, 16'(12'h020 << c));
    end
    test_done();
  end
endmodule
`default_nettype wire
